// ### common/sbst_pkg.sv
// sbst_pkg: constants, field layout and types for the boundary scan test port.
// assumes: apb slave on the main clock, test logic on the link test clock.
// Notes on behaviour
// [RL1] state moves on mode-select at test clock rise
// [RL2] chains: instr 3, bypass 1, id 32, boundary 107
// [RL3] code 000: external test drives preloaded outputs
// [RL4] code 001: id word captured and shifted out
// [RL5] code 010: sample, memory outputs forced off
// [RL6] code 100: sample/preload, memory left alone
// [RL7] code 111: single bypass bit between data pins
// [RL8] host never loads codes 011, 101, 110
// [RL9] id bits 31:29 revision, 28:12 part
// [RL10] id bits 11:1 hold maker code
// [RL11] id bit 0 always reads one
// [RL12] five mode-select highs reset the port
// [RL13] data in on rise, out on fall
// [RL14] ir capture loads 01; reset selects id
// [RL15] boundary cell 47 gates output bus, presets high
// [RL16] full sixteen-state test access controller
// [RL17] new instruction acts only at update-ir
`default_nettype none
package sbst_pkg;
   localparam int IR_W         = 3;
   localparam int ID_W         = 32;
   localparam int BSR_W        = 107;
   localparam int BSR_OE_BIT   = 47;
   localparam logic BSR_OE_RST = 1'b1;

   localparam logic [IR_W-1:0] IR_CAP     = 3'h1;
   localparam logic [IR_W-1:0] OP_EXTEST  = 3'h0;
   localparam logic [IR_W-1:0] OP_IDCODE  = 3'h1;
   localparam logic [IR_W-1:0] OP_SAMPZ   = 3'h2;
   localparam logic [IR_W-1:0] OP_PRELOAD = 3'h4;
   localparam logic [IR_W-1:0] OP_BYPASS  = 3'h7;

   localparam int ID_REV_W     = 3;
   localparam int ID_PART_W    = 17;
   localparam int ID_MAKER_W   = 11;
   localparam int ID_REV_LSB   = 29;
   localparam int ID_PART_LSB  = 12;
   localparam int ID_MAKER_LSB = 1;
   localparam int ID_PRES_BIT  = 0;
   localparam logic ID_PRESENT = 1'b1;

   localparam int ADDR_W                 = 8;
   localparam int DATA_W                 = 32;
   localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] REG_ID     = 8'h08;
   localparam int CTRL_RST_BIT           = 0;

   typedef enum logic [3:0] {
      S_TLR, S_RTI,
      S_SEL_DR, S_CAP_DR, S_SH_DR, S_EX1_DR, S_PAU_DR, S_EX2_DR, S_UPD_DR,
      S_SEL_IR, S_CAP_IR, S_SH_IR, S_EX1_IR, S_PAU_IR, S_EX2_IR, S_UPD_IR
   } sbst_state_t;

   typedef struct packed {
      logic [IR_W-1:0] instr;
      sbst_state_t     state;
   } sbst_status_t;
endpackage
`default_nettype wire

// ### verilog/sbst_sync.sv
// sbst_sync: three-stage level synchroniser for signals from another domain.
// assumes: i_clk is the destination clock and i_rst_n is already released on it.
`default_nettype none
module sbst_sync
   import sbst_pkg::*;
#(
   parameter int W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   input  wire logic [W-1:0] i_d,
   output var  logic [W-1:0] o_q
);
   logic [W-1:0] ff1;
   logic [W-1:0] ff2;
   logic [W-1:0] ff3;
   logic [W-1:0] next_q;

   // ff1 is read by ff2 only; a bit moves once ff2 and ff3 agree
   always_comb begin
      next_q = ((ff2 ~^ ff3) & ff3) | ((ff2 ^ ff3) & o_q);
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ff1 <= '0;
         ff2 <= '0;
         ff3 <= '0;
         o_q <= '0;
      end else begin
         ff1 <= i_d;
         ff2 <= ff1;
         ff3 <= ff2;
         o_q <= next_q;
      end
   end
endmodule
`default_nettype wire

// ### verilog/sbst_tap_fsm.sv
// sbst_tap_fsm: sixteen-state test access controller, stepped by mode-select.
// assumes: i_tms and i_force_rst are already on the test clock.
`default_nettype none
module sbst_tap_fsm
   import sbst_pkg::*;
(
   input  wire logic  i_tck,
   input  wire logic  i_rst_n,
   input  wire logic  i_tms,
   input  wire logic  i_force_rst,
   output var  sbst_state_t o_state
);
   sbst_state_t next_state;

   always_comb begin
      case (o_state) // [RL1] [RL16]
         S_TLR:    next_state = i_tms ? S_TLR    : S_RTI; // [RL12]
         S_RTI:    next_state = i_tms ? S_SEL_DR : S_RTI;
         S_SEL_DR: next_state = i_tms ? S_SEL_IR : S_CAP_DR;
         S_CAP_DR: next_state = i_tms ? S_EX1_DR : S_SH_DR;
         S_SH_DR:  next_state = i_tms ? S_EX1_DR : S_SH_DR;
         S_EX1_DR: next_state = i_tms ? S_UPD_DR : S_PAU_DR;
         S_PAU_DR: next_state = i_tms ? S_EX2_DR : S_PAU_DR;
         S_EX2_DR: next_state = i_tms ? S_UPD_DR : S_SH_DR;
         S_UPD_DR: next_state = i_tms ? S_SEL_DR : S_RTI;
         S_SEL_IR: next_state = i_tms ? S_TLR    : S_CAP_IR;
         S_CAP_IR: next_state = i_tms ? S_EX1_IR : S_SH_IR;
         S_SH_IR:  next_state = i_tms ? S_EX1_IR : S_SH_IR;
         S_EX1_IR: next_state = i_tms ? S_UPD_IR : S_PAU_IR;
         S_PAU_IR: next_state = i_tms ? S_EX2_IR : S_PAU_IR;
         S_EX2_IR: next_state = i_tms ? S_UPD_IR : S_SH_IR;
         S_UPD_IR: next_state = i_tms ? S_SEL_DR : S_RTI;
         default:  next_state = S_TLR;
      endcase
      if (i_force_rst) begin
         next_state = S_TLR;
      end
   end

   always_ff @(posedge i_tck or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_state <= S_TLR;
      end else begin
         o_state <= next_state;
      end
   end

   default clocking fsm_cb @(posedge i_tck);
   endclocking
   default disable iff (!i_rst_n);

   five_tms_reset_a: assert property (i_tms [*5] |=> o_state == S_TLR) // [RL12]
      else $error("five mode-select highs did not reach reset");
   dr_walk_a: assert property ( // [RL16]
      o_state == S_SEL_DR && !i_tms && !i_force_rst ##1 !i_tms && !i_force_rst |=> o_state == S_SH_DR)
      else $error("select-dr, capture-dr did not lead to shift-dr");
   ir_exit_a: assert property (o_state == S_SH_IR && i_tms && !i_force_rst |=> o_state == S_EX1_IR) // [RL1]
      else $error("shift-ir with mode-select high did not exit");
endmodule
`default_nettype wire

// ### verilog/sbst_tap_top.sv
// sbst_tap_top: boundary scan test port with its scan chains and an apb status view.
// assumes: i_tck runs free from reset release; i_ring is the memory pin ring, unsynchronised.
`default_nettype none
module sbst_tap_top
   import sbst_pkg::*;
#(
   parameter logic [ID_REV_W-1:0]   ID_REV   = 3'h5,     // arbitrary value
   parameter logic [ID_PART_W-1:0]  ID_PART  = 17'h0a5a5, // arbitrary value
   parameter logic [ID_MAKER_W-1:0] ID_MAKER = 11'h155    // arbitrary value
) (
   input  wire logic              i_mclk,
   input  wire logic              i_rst_n,
   input  wire logic              i_psel,
   input  wire logic              i_penable,
   input  wire logic              i_pwrite,
   input  wire logic [ADDR_W-1:0] i_paddr,
   input  wire logic [DATA_W-1:0] i_pwdata,
   output var  logic [DATA_W-1:0] o_prdata,
   output var  logic              o_pready,
   output var  logic              o_pslverr,
   input  wire logic              i_tck,
   input  wire logic              i_tms,
   input  wire logic              i_tdi,
   output var  logic              o_tdo,
   output var  logic              o_tdo_oe,
   input  wire logic [BSR_W-1:0]  i_ring,
   output logic      [BSR_W-1:0]  o_ring,
   output var  logic              o_ring_drive,
   output var  logic              o_qbus_oe
);
   logic [1:0]        rst_tck_q;
   logic              rst_tck_n;
   sbst_state_t       state;
   logic [BSR_W-1:0]  ring_s;
   logic              force_rst_s;
   logic              req_s;
   logic              ack_s;
   logic [ID_W-1:0]   id_word;

   logic [IR_W-1:0]   ir_sh;
   logic [IR_W-1:0]   ir_cur;
   logic [BSR_W-1:0]  bsr;
   logic [BSR_W-1:0]  bsr_upd;
   logic [ID_W-1:0]   id_sh;
   logic              byp;
   logic              ack;
   sbst_status_t      stat_hold;
   logic [IR_W-1:0]   next_ir_sh;
   logic [IR_W-1:0]   next_ir_cur;
   logic [BSR_W-1:0]  next_bsr;
   logic [BSR_W-1:0]  next_bsr_upd;
   logic [ID_W-1:0]   next_id_sh;
   logic              next_byp;
   logic              next_ack;
   sbst_status_t      next_stat_hold;
   logic              next_ring_drive;
   logic              next_qbus_oe;
   logic              sel_bsr;
   logic              sel_id;
   logic              dr_out;
   logic              next_tdo;
   logic              next_tdo_oe;

   logic              ctrl_rst;
   logic              req;
   sbst_status_t      status;
   logic              next_ctrl_rst;
   logic              next_req;
   sbst_status_t      next_status;
   logic [DATA_W-1:0] next_prdata;
   logic              next_pready;
   logic              next_pslverr;
   logic              apb_setup;
   logic              apb_hit;
   logic [DATA_W-1:0] rd_mux;

   // test reset asserts at once, releases on the test clock
   always_ff @(posedge i_tck or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_tck_q <= '0;
      end else begin
         rst_tck_q <= {rst_tck_q[0], 1'b1};
      end
   end
   assign rst_tck_n = rst_tck_q[1];

   sbst_sync #(.W(BSR_W)) u_ring_sync (
      .i_clk   (i_tck),
      .i_rst_n (rst_tck_n),
      .i_d     (i_ring),
      .o_q     (ring_s)
   );
   sbst_sync #(.W(1)) u_frst_sync (
      .i_clk   (i_tck),
      .i_rst_n (rst_tck_n),
      .i_d     (ctrl_rst),
      .o_q     (force_rst_s)
   );
   sbst_sync #(.W(1)) u_req_sync (
      .i_clk   (i_tck),
      .i_rst_n (rst_tck_n),
      .i_d     (req),
      .o_q     (req_s)
   );
   sbst_sync #(.W(1)) u_ack_sync (
      .i_clk   (i_mclk),
      .i_rst_n (i_rst_n),
      .i_d     (ack),
      .o_q     (ack_s)
   );

   sbst_tap_fsm u_fsm (
      .i_tck       (i_tck),
      .i_rst_n     (rst_tck_n),
      .i_tms       (i_tms),
      .i_force_rst (force_rst_s),
      .o_state     (state)
   );

   always_comb begin
      id_word = '0;
      id_word[ID_REV_LSB +: ID_REV_W]     = ID_REV;    // [RL9]
      id_word[ID_PART_LSB +: ID_PART_W]   = ID_PART;   // [RL9]
      id_word[ID_MAKER_LSB +: ID_MAKER_W] = ID_MAKER;  // [RL10]
      id_word[ID_PRES_BIT]                = ID_PRESENT; // [RL11]
   end

   // reserved codes fall through to bypass, so a stray load stays harmless
   assign sel_bsr = (ir_cur == OP_EXTEST) || (ir_cur == OP_SAMPZ) || (ir_cur == OP_PRELOAD);
   assign sel_id  = (ir_cur == OP_IDCODE);
   assign dr_out  = sel_bsr ? bsr[0] : (sel_id ? id_sh[0] : byp);

   always_comb begin
      next_ir_sh   = ir_sh;
      next_ir_cur  = ir_cur;
      next_bsr     = bsr;
      next_bsr_upd = bsr_upd;
      next_id_sh   = id_sh;
      next_byp     = byp;
      case (state)
         S_TLR: begin
            next_ir_cur              = OP_IDCODE;  // [RL14]
            next_bsr_upd[BSR_OE_BIT] = BSR_OE_RST; // [RL15]
         end
         S_CAP_IR: next_ir_sh  = IR_CAP;                      // [RL14]
         S_SH_IR:  next_ir_sh  = {i_tdi, ir_sh[IR_W-1:1]};    // [RL2]
         S_UPD_IR: next_ir_cur = ir_sh;                       // [RL17]
         S_CAP_DR: begin
            if (sel_bsr) begin
               next_bsr = ring_s; // [RL3] [RL5] [RL6]
            end else if (sel_id) begin
               next_id_sh = id_word; // [RL4]
            end else begin
               next_byp = 1'b0; // [RL7]
            end
         end
         S_SH_DR: begin
            if (sel_bsr) begin
               next_bsr = {i_tdi, bsr[BSR_W-1:1]}; // [RL2]
            end else if (sel_id) begin
               next_id_sh = {i_tdi, id_sh[ID_W-1:1]}; // [RL2]
            end else begin
               next_byp = i_tdi; // [RL7]
            end
         end
         S_UPD_DR: begin
            if (ir_cur == OP_EXTEST || ir_cur == OP_PRELOAD) begin
               next_bsr_upd = bsr; // [RL3] [RL6]
            end
         end
         default: ;
      endcase
      next_ring_drive = (next_ir_cur == OP_EXTEST); // [RL3]
      case (next_ir_cur)
         OP_EXTEST: next_qbus_oe = next_bsr_upd[BSR_OE_BIT]; // [RL15]
         OP_SAMPZ:  next_qbus_oe = 1'b0;                     // [RL5]
         default:   next_qbus_oe = 1'b1;
      endcase
   end

   always_ff @(posedge i_tck or negedge rst_tck_n) begin
      if (!rst_tck_n) begin
         ir_sh        <= '0;
         ir_cur       <= OP_IDCODE;
         bsr          <= '0;
         bsr_upd      <= {{(BSR_W-BSR_OE_BIT-1){1'b0}}, BSR_OE_RST, {BSR_OE_BIT{1'b0}}};
         id_sh        <= '0;
         byp          <= 1'b0;
         o_ring_drive <= 1'b0;
         o_qbus_oe    <= 1'b1;
      end else begin
         ir_sh        <= next_ir_sh;
         ir_cur       <= next_ir_cur;
         bsr          <= next_bsr;
         bsr_upd      <= next_bsr_upd;
         id_sh        <= next_id_sh;
         byp          <= next_byp;
         o_ring_drive <= next_ring_drive;
         o_qbus_oe    <= next_qbus_oe;
      end
   end
   assign o_ring = bsr_upd;

   // output pin changes on the falling edge, half a cycle of margin for the far end
   always_comb begin
      next_tdo    = o_tdo;
      next_tdo_oe = 1'b0;
      if (state == S_SH_IR) begin
         next_tdo    = ir_sh[0]; // [RL13]
         next_tdo_oe = 1'b1;
      end else if (state == S_SH_DR) begin
         next_tdo    = dr_out; // [RL13]
         next_tdo_oe = 1'b1;
      end
   end

   always_ff @(negedge i_tck or negedge rst_tck_n) begin
      if (!rst_tck_n) begin
         o_tdo    <= 1'b0;
         o_tdo_oe <= 1'b0;
      end else begin
         o_tdo    <= next_tdo;
         o_tdo_oe <= next_tdo_oe;
      end
   end

   // status snapshot: toggle handshake, stat_hold stands still while req and ack agree
   always_comb begin
      next_ack       = ack;
      next_stat_hold = stat_hold;
      if (req_s != ack) begin
         next_stat_hold.instr = ir_cur;
         next_stat_hold.state = state;
         next_ack             = req_s;
      end
   end

   always_ff @(posedge i_tck or negedge rst_tck_n) begin
      if (!rst_tck_n) begin
         ack       <= 1'b0;
         stat_hold <= '0;
      end else begin
         ack       <= next_ack;
         stat_hold <= next_stat_hold;
      end
   end

   assign apb_setup = i_psel && !i_penable;
   assign apb_hit   = (i_paddr == REG_CTRL) || (i_paddr == REG_STATUS) || (i_paddr == REG_ID);

   always_comb begin
      case (i_paddr)
         REG_CTRL:   rd_mux = DATA_W'(ctrl_rst);
         REG_STATUS: rd_mux = DATA_W'(status);
         REG_ID:     rd_mux = id_word;
         default:    rd_mux = '0;
      endcase
   end

   always_comb begin
      next_req      = req;
      next_status   = status;
      next_ctrl_rst = ctrl_rst;
      if (ack_s == req) begin
         next_status = stat_hold;
         next_req    = !req;
      end
      if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == REG_CTRL) begin
         next_ctrl_rst = i_pwdata[CTRL_RST_BIT];
      end
      next_pready  = apb_setup;
      next_pslverr = apb_setup && !apb_hit;
      next_prdata  = (apb_setup && !i_pwrite) ? rd_mux : '0;
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         req       <= 1'b0;
         status    <= '0;
         ctrl_rst  <= 1'b0;
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata  <= '0;
      end else begin
         req       <= next_req;
         status    <= next_status;
         ctrl_rst  <= next_ctrl_rst;
         o_pready  <= next_pready;
         o_pslverr <= next_pslverr;
         o_prdata  <= next_prdata;
      end
   end

   default clocking tck_cb @(posedge i_tck);
   endclocking
   default disable iff (!rst_tck_n);

   capture_ir_a: assert property (state == S_CAP_IR |=> ir_sh[1:0] == 2'h1) // [RL14]
      else $error("capture-ir did not load 01");
   reset_instr_a: assert property (state == S_TLR |=> ir_cur == OP_IDCODE && o_qbus_oe) // [RL14]
      else $error("reset did not select identification");
   ir_hold_a: assert property (state != S_UPD_IR && state != S_TLR |=> $stable(ir_cur)) // [RL17]
      else $error("instruction changed outside update-ir");
   id_capture_a: assert property (state == S_CAP_DR && ir_cur == OP_IDCODE |=> id_sh == id_word) // [RL4]
      else $error("identification word not captured");
   bypass_zero_a: assert property (state == S_CAP_DR && ir_cur == OP_BYPASS |=> !byp) // [RL7]
      else $error("bypass bit not cleared at capture");
   samplez_hiz_a: assert property (ir_cur == OP_SAMPZ |-> !o_qbus_oe && !o_ring_drive) // [RL5]
      else $error("output bus driven under sample-z");
   extest_oe_a: assert property (ir_cur == OP_EXTEST |-> o_qbus_oe == bsr_upd[BSR_OE_BIT] && o_ring_drive) // [RL15]
      else $error("output enable cell not steering bus");
   update_dr_a: assert property (state == S_UPD_DR && ir_cur == OP_EXTEST |=> bsr_upd == $past(bsr)) // [RL3]
      else $error("preload latch not updated");
   bsr_capture_a: assert property (state == S_CAP_DR && ir_cur == OP_PRELOAD |=> bsr == $past(ring_s)) // [RL6]
      else $error("pin ring not captured");
   bsr_shift_a: assert property (state == S_SH_DR && sel_bsr |=> bsr[BSR_W-1] == $past(i_tdi)) // [RL2]
      else $error("boundary chain did not take serial input");
   tdo_path_a: assert property (state == S_SH_IR |-> o_tdo == ir_sh[0] && o_tdo_oe) // [RL13]
      else $error("serial output not from instruction lsb");

   samplez_load_c: cover property (state == S_UPD_IR && ir_sh == OP_SAMPZ);
   id_shift_c: cover property (state == S_SH_DR && sel_id ##1 state == S_SH_DR);
   extest_hiz_c: cover property (ir_cur == OP_EXTEST && !o_qbus_oe);
endmodule
`default_nettype wire

// ### verif/sbst_jtag_host.sv
// sbst_jtag_host: board test controller model that drives the test port pins.
// assumes: the port samples mode and data on clock rise and shifts out on fall.
`default_nettype none
module sbst_jtag_host
   import sbst_pkg::*;
(
   input  wire logic i_tdo,
   output var  logic o_tck,
   output var  logic o_tms,
   output var  logic o_tdi
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      o_tck = 1'b0;
      o_tms = 1'b1;
      o_tdi = 1'b0;
   end

   // clock stands low between frames; tdo is taken at rise, long after the fall that moved it
   task automatic step(input logic tms, input logic tdi, output logic tdo);
      o_tms <= tms;
      o_tdi <= tdi;
      #7.5 o_tck = 1'b1;
      tdo = i_tdo;
      #7.5 o_tck = 1'b0;
   endtask

   task automatic idle(input int n);
      logic d;
      repeat (n) step(1'b0, ~o_tdi, d);
   endtask

   task automatic walk(input logic [3:0] seq, input int n);
      logic d;
      for (int i = 0; i < n; i++) begin
         step(seq[i], 1'b0, d);
      end
   endtask

   task automatic tap_reset();
      walk(4'hf, 4);
      walk(4'h1, 2);
   endtask

   // lsb first; last bit leaves shift, then update and back to idle
   task automatic scan(input logic [127:0] din, input int n, output logic [127:0] dout);
      dout = '0;
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], dout[i]);
      end
      walk(4'h1, 2);
   endtask

   // only defined codes are ever loaded
   task automatic load_ir(input logic [IR_W-1:0] code, output logic [IR_W-1:0] cap);
      logic [127:0] q;
      walk(4'h3, 4);
      scan({125'h0, code}, IR_W, q);
      cap = q[IR_W-1:0];
   endtask

   task automatic load_dr(input logic [127:0] din, input int n, output logic [127:0] dout);
      walk(4'h1, 3);
      scan(din, n, dout);
   endtask
endmodule
`default_nettype wire

// ### verif/sbst_tap_top_tb.sv
// sbst_tap_top_tb: scan chain and register tests of the test port.
// assumes: host model steps the test clock; apb master here on the main clock.
`default_nettype none
module sbst_tap_top_tb
   import sbst_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   localparam logic [2:0]  T_REV   = 3'h5;     // arbitrary value, left at the port's default
   localparam logic [16:0] T_PART  = 17'h01234; // arbitrary value
   localparam logic [10:0] T_MAKER = 11'h2a6;   // arbitrary value
   localparam logic [31:0] ID_WORD = {T_REV, T_PART, T_MAKER, 1'b1};
   localparam logic [BSR_W-1:0] RING = {3'h5, {13{8'hc3}}};
   localparam logic [BSR_W-1:0] PRE  = {3'h2, {13{8'h69}}};
   localparam logic [BSR_W-1:0] OE_ONLY = 107'h1 << BSR_OE_BIT;
   // inverted patterns held at chain width, so no stray ones above bit 106
   localparam logic [BSR_W-1:0] NRING   = ~RING;
   localparam logic [BSR_W-1:0] NPRE    = ~PRE;

   logic              mclk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, rd;
   logic              tck, tms, tdi, tdo, tdo_oe, ring_drive, qbus_oe, err;
   logic [BSR_W-1:0]  ring_in, ring_out;
   logic [IR_W-1:0]   cap;
   logic [127:0]      q;
   int                n_errors = 0;
   int                compares = 0;
   int                cycles = 0;

   sbst_tap_top #(.ID_PART(T_PART), .ID_MAKER(T_MAKER)) dut_u (
      .i_mclk(mclk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_ring(ring_in),
      .o_ring(ring_out), .o_ring_drive(ring_drive), .o_qbus_oe(qbus_oe));

   sbst_jtag_host host_u (.i_tdo(tdo), .o_tck(tck), .o_tms(tms), .o_tdi(tdi));

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // a hang of the handshake or the host ends here
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         report_and_stop();
      end
   end

   task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   initial begin
      rst_n = 1'b0;
      {psel, penable, pwrite} = 3'b000;
      paddr = '0;
      pwdata = '0;
      ring_in = RING;
      host_u.idle(2);
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      check("qbus_oe rst", qbus_oe, 1'b1);
      check("ring rst", ring_out, OE_ONLY);
      check("drive rst", {ring_drive, tdo_oe}, 2'b00);
      host_u.tap_reset();
      apb(1'b0, REG_ID, '0);
      check("id reg", rd, ID_WORD);
      host_u.load_dr('0, ID_W, q);
      check("id scan", q, ID_WORD);
      $display("test id done");

      host_u.load_ir(OP_BYPASS, cap);
      check("ir capture", cap, IR_CAP);
      host_u.load_dr(128'hb5, 8, q);
      check("bypass", q, 128'h6a);
      check("bypass oe", qbus_oe, 1'b1);
      host_u.idle(40);
      apb(1'b0, REG_STATUS, '0);
      check("status", rd[6:0], {OP_BYPASS, 4'h1});
      $display("test bypass done");

      host_u.load_ir(OP_PRELOAD, cap);
      host_u.idle(4);
      host_u.load_dr(PRE, BSR_W, q);
      check("sample", q[BSR_W-1:0], RING);
      check("preload", ring_out, PRE);
      check("preload oe", {qbus_oe, ring_drive}, 2'b10);
      $display("test preload done");

      host_u.load_ir(OP_EXTEST, cap);
      check("extest oe", {qbus_oe, ring_drive}, 2'b01);
      ring_in <= NRING;
      host_u.idle(4);
      host_u.load_dr({21'h0, NPRE}, BSR_W, q);
      check("extest cap", q[BSR_W-1:0], NRING);
      check("extest out", ring_out, NPRE);
      check("extest oe hi", qbus_oe, 1'b1);
      $display("test extest done");

      host_u.load_ir(OP_SAMPZ, cap);
      check("hiz oe", {qbus_oe, ring_drive}, 2'b00);
      host_u.load_dr(PRE, BSR_W, q);
      check("hiz cap", q[BSR_W-1:0], NRING);
      check("hiz latch", ring_out, NPRE);
      $display("test sample z done");

      // clear the enable cell first so the reset preset is really seen
      host_u.load_ir(OP_PRELOAD, cap);
      host_u.load_dr(PRE, BSR_W, q);
      check("pre rst oe", ring_out[BSR_OE_BIT], 1'b0);

      host_u.tap_reset();
      check("tlr oe", {qbus_oe, ring_drive, ring_out[BSR_OE_BIT]}, 3'b101);
      host_u.load_dr('0, ID_W, q);
      check("tlr id", q, ID_WORD);
      $display("test tap reset done");

      host_u.load_ir(OP_BYPASS, cap);
      apb(1'b1, REG_CTRL, 32'h1);
      apb(1'b0, REG_CTRL, '0);
      check("ctrl", rd, 32'h1);
      host_u.idle(40);
      apb(1'b0, REG_STATUS, '0);
      check("forced", rd[6:0], {OP_IDCODE, 4'h0});
      apb(1'b1, REG_CTRL, 32'h0);
      apb(1'b0, 8'h0c, '0);
      check("unmapped", {err, rd}, 33'h100000000);
      host_u.idle(40);
      host_u.load_dr('0, ID_W, q);
      check("after ctrl", q, ID_WORD);
      $display("test apb done");
      report_and_stop();
   end
endmodule
`default_nettype wire
